//--- design/tpep_top.sv
// PA protection error flags, status capture, interrupt and APB register file
`timescale 1ns/1ps
`include "tpep_cfg.svh"
module tpep_top
  import tpep_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Per-channel transmit sample power
  input wire logic [`TPEP_CH_N-1:0] sample_valid,
  input wire logic [`TPEP_CH_N*16-1:0] sample_power,
  // Other ramp-down event sources, level
  input wire logic pll_unlock_in,
  input wire logic deframer_irq_in,
  // Interrupts
  output logic general_purpose_irq_out,
  output logic pll_event_out,
  output logic deframer_event_out
);

  localparam int CH = `TPEP_CH_N;
  // Register state
  tpep_chmask_t avg_en_reg, peak_en_reg, ratio_en_reg;
  tpep_chmask_t sticky_avg_reg, sticky_peak_reg;
  tpep_chmask_t irq_en_reg;
  logic [3:0] win_log2_reg;
  tpep_pwr_t avg_lim_reg [CH];
  tpep_pwr_t pk_lim_reg [CH];
  logic [7:0] pk_cnt_lim_reg [CH];
  // Measurement state
  logic [31:0] acc_reg [CH];
  logic [15:0] win_cnt_reg;
  logic [7:0] peak_seen_reg [CH];
  tpep_pwr_t peak_max_reg [CH];
  tpep_pwr_t average_power_result [CH];
  tpep_pwr_t average_to_peak_ratio [CH];
  tpep_pwr_t average_error_power_latch [CH];
  tpep_chmask_t peak_power_error_flag, average_power_error_flag;
  tpep_chmask_t peak_live, avg_live, avg_done;
  tpep_chmask_t irq_stat_reg;
  logic pll_ev_reg, dfr_ev_reg;
  tpep_pwr_t avg_now [CH];
  logic win_end;
  // APB decode, channel block taken from the offset past the channel base
  logic wr_en;
  logic [11:0] ch_rel;
  logic [2:0] ch_off;
  logic [1:0] ch_idx;
  logic ch_hit;
  assign wr_en = psel & penable & pwrite & pready;
  assign ch_rel = paddr - `TPEP_OFF_CH_BASE;
  assign ch_hit = paddr >= `TPEP_OFF_CH_BASE && ch_rel[11:`TPEP_CH_STRIDE_LSB + `TPEP_CH_STRIDE_W] == '0;
  assign ch_idx = ch_rel[`TPEP_CH_STRIDE_LSB +: `TPEP_CH_STRIDE_W];
  assign ch_off = paddr[4:2];
  // Write strobes for clear actions; bus state passed in so continuous assigns stay sensitive
  function automatic logic wr_at(input logic wr, input logic [11:0] a, input logic [11:0] off);
    return wr && a == off;
  endfunction
  logic flag_rst_wr, ev_clr_wr;
  assign flag_rst_wr = wr_at(wr_en, paddr, `TPEP_OFF_FLAGRST);
  assign ev_clr_wr = wr_at(wr_en, paddr, `TPEP_OFF_EVCLR);
  // Window length 2^n samples, one shared window timer
  assign win_end = win_cnt_reg == 16'((32'h1 << win_log2_reg) - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt_reg <= 16'h0000;
    end else if (|sample_valid) begin
      win_cnt_reg <= win_end ? 16'h0000 : 16'(win_cnt_reg + 16'h0001);
    end
  end
  // Average of current window, accumulator divided by 2^n
  always_comb begin
    for (int i = 0; i < CH; i++) begin
      avg_now[i] = 16'((acc_reg[i] + {16'h0000, sample_power[i*16 +: 16]}) >> win_log2_reg);
    end
  end
  // Per-channel accumulation and peak counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < CH; i++) begin
        acc_reg[i] <= 32'h0;
        peak_seen_reg[i] <= 8'h00;
        peak_max_reg[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < CH; i++) begin
        if (sample_valid[i]) begin
          if (win_end) begin
            acc_reg[i] <= 32'h0;
            peak_seen_reg[i] <= 8'h00;
            peak_max_reg[i] <= 16'h0000;
          end else begin
            acc_reg[i] <= acc_reg[i] + {16'h0000, sample_power[i*16 +: 16]};
            if (peak_en_reg[i] && sample_power[i*16 +: 16] > pk_lim_reg[i] && peak_seen_reg[i] != 8'hFF) begin
              peak_seen_reg[i] <= 8'(peak_seen_reg[i] + 8'h01);
            end
            if (sample_power[i*16 +: 16] > peak_max_reg[i]) begin
              peak_max_reg[i] <= sample_power[i*16 +: 16];
            end
          end
        end
      end
    end
  end
  // Live error conditions
  always_comb begin
    for (int i = 0; i < CH; i++) begin
      avg_done[i] = sample_valid[i] & win_end & avg_en_reg[i];
      peak_live[i] = peak_en_reg[i] & (peak_seen_reg[i] > pk_cnt_lim_reg[i]);
      avg_live[i] = avg_done[i] & (avg_now[i] > avg_lim_reg[i]);
    end
  end
  // Status results: latest average, ratio, error power
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < CH; i++) begin
        average_power_result[i] <= 16'h0000;
        average_to_peak_ratio[i] <= 16'h0000;
        average_error_power_latch[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < CH; i++) begin
        if (avg_done[i]) begin
          average_power_result[i] <= avg_now[i];
          if (ratio_en_reg[i] && peak_en_reg[i] && peak_max_reg[i] != 16'h0000) begin
            average_to_peak_ratio[i] <= 16'(({16'h0000, avg_now[i]} << `TPEP_RATIO_SHIFT) / peak_max_reg[i]);
          end
        end
        if (avg_live[i]) begin
          average_error_power_latch[i] <= avg_now[i];
        end
      end
    end
  end
  // Error flags: sticky hold or live follow, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peak_power_error_flag <= 4'h0;
      average_power_error_flag <= 4'h0;
    end else begin
      for (int i = 0; i < CH; i++) begin
        if (peak_live[i]) begin
          peak_power_error_flag[i] <= 1'b1;
        end else if (!sticky_peak_reg[i]) begin
          peak_power_error_flag[i] <= 1'b0;
        end else if ((flag_rst_wr && pwdata[i] && (pwdata[9:8] & `TPEP_SEL_PEAK) != 2'h0) ||
                     (ev_clr_wr && pwdata[i])) begin
          peak_power_error_flag[i] <= 1'b0;
        end
        if (avg_live[i]) begin
          average_power_error_flag[i] <= 1'b1;
        end else if (!sticky_avg_reg[i]) begin
          if (avg_done[i]) begin
            average_power_error_flag[i] <= 1'b0;
          end
        end else if ((flag_rst_wr && pwdata[i] && (pwdata[9:8] & `TPEP_SEL_AVG) != 2'h0) ||
                     (ev_clr_wr && pwdata[i])) begin
          average_power_error_flag[i] <= 1'b0;
        end
      end
    end
  end
  // Other event latches, cleared only by event clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_ev_reg <= 1'b0;
      dfr_ev_reg <= 1'b0;
    end else begin
      if (pll_unlock_in) begin
        pll_ev_reg <= 1'b1;
      end else if (ev_clr_wr && pwdata[16]) begin
        pll_ev_reg <= 1'b0;
      end
      if (deframer_irq_in) begin
        dfr_ev_reg <= 1'b1;
      end else if (ev_clr_wr && pwdata[17]) begin
        dfr_ev_reg <= 1'b0;
      end
    end
  end
  // Sticky interrupt status per channel, write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= 4'h0;
    end else begin
      for (int i = 0; i < CH; i++) begin
        if (peak_live[i] || avg_live[i]) begin
          irq_stat_reg[i] <= 1'b1;
        end else if (wr_at(wr_en, paddr, `TPEP_OFF_IRQ_CLR) && pwdata[i]) begin
          irq_stat_reg[i] <= 1'b0;
        end
      end
    end
  end
  // Interrupt and event outputs, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_purpose_irq_out <= 1'b0;
      pll_event_out <= 1'b0;
      deframer_event_out <= 1'b0;
    end else begin
      general_purpose_irq_out <= |(peak_power_error_flag | average_power_error_flag) |
                                 |(irq_stat_reg & irq_en_reg);
      pll_event_out <= pll_ev_reg;
      deframer_event_out <= dfr_ev_reg;
    end
  end
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      avg_en_reg <= 4'h0;
      peak_en_reg <= 4'h0;
      ratio_en_reg <= 4'h0;
      sticky_avg_reg <= 4'hF;
      sticky_peak_reg <= 4'hF;
      irq_en_reg <= 4'h0;
      win_log2_reg <= `TPEP_WIN_RST;
      for (int i = 0; i < CH; i++) begin
        avg_lim_reg[i] <= `TPEP_AVG_LIM_RST;
        pk_lim_reg[i] <= `TPEP_PK_LIM_RST;
        pk_cnt_lim_reg[i] <= `TPEP_PK_CNT_RST;
      end
    end else if (wr_en) begin
      if (paddr == `TPEP_OFF_CTRL) begin
        avg_en_reg <= pwdata[3:0];
        peak_en_reg <= pwdata[7:4];
        ratio_en_reg <= pwdata[11:8];
      end
      if (paddr == `TPEP_OFF_STICKY) begin
        sticky_avg_reg <= pwdata[3:0];
        sticky_peak_reg <= pwdata[7:4];
      end
      if (paddr == `TPEP_OFF_IRQ_EN) begin
        irq_en_reg <= pwdata[3:0];
      end
      if (paddr == `TPEP_OFF_WIN) begin
        win_log2_reg <= pwdata[3:0];
      end
      if (ch_hit && ch_off == `TPEP_OFF_CH_AVGLIM) begin
        avg_lim_reg[ch_idx] <= pwdata[15:0];
      end
      if (ch_hit && ch_off == `TPEP_OFF_CH_PKLIM) begin
        pk_lim_reg[ch_idx] <= pwdata[15:0];
      end
      if (ch_hit && ch_off == `TPEP_OFF_CH_PKCNT) begin
        pk_cnt_lim_reg[ch_idx] <= pwdata[7:0];
      end
    end
  end
  // APB read mux
  logic [31:0] rd_val;
  logic rd_ok;
  always_comb begin
    rd_val = 32'h0;
    rd_ok = 1'b1;
    if (ch_hit) begin
      unique case (ch_off)
        `TPEP_OFF_CH_AVGLIM: rd_val = {16'h0000, avg_lim_reg[ch_idx]};
        `TPEP_OFF_CH_PKLIM: rd_val = {16'h0000, pk_lim_reg[ch_idx]};
        `TPEP_OFF_CH_PKCNT: rd_val = {24'h000000, pk_cnt_lim_reg[ch_idx]};
        `TPEP_OFF_CH_AVG: rd_val = {16'h0000, average_power_result[ch_idx]};
        `TPEP_OFF_CH_RATIO: rd_val = {16'h0000, average_to_peak_ratio[ch_idx]};
        `TPEP_OFF_CH_ERRPWR: rd_val = {16'h0000, average_error_power_latch[ch_idx]};
        default: rd_ok = 1'b0;
      endcase
    end else begin
      unique case (paddr)
        `TPEP_OFF_CTRL: rd_val = {20'h00000, ratio_en_reg, peak_en_reg, avg_en_reg};
        `TPEP_OFF_STICKY: rd_val = {24'h000000, sticky_peak_reg, sticky_avg_reg};
        `TPEP_OFF_FLAGS: rd_val = {14'h0000, dfr_ev_reg, pll_ev_reg, 8'h00,
                                   peak_power_error_flag, average_power_error_flag};
        `TPEP_OFF_IRQ_STAT: rd_val = {28'h0000000, irq_stat_reg};
        `TPEP_OFF_IRQ_EN: rd_val = {28'h0000000, irq_en_reg};
        `TPEP_OFF_WIN: rd_val = {28'h0000000, win_log2_reg};
        `TPEP_OFF_FLAGRST, `TPEP_OFF_EVCLR, `TPEP_OFF_IRQ_CLR: rd_val = 32'h0;
        default: rd_ok = 1'b0;
      endcase
    end
  end
  // APB response: no wait states, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_ok;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  // Checks
  property p_flag_irq;
    @(posedge pclk) disable iff (!presetn)
      |(peak_power_error_flag | average_power_error_flag) |=> general_purpose_irq_out;
  endproperty
  a_flag_irq: assert property (p_flag_irq) else $error("irq low with flag set");
  property p_peak_set;
    @(posedge pclk) disable iff (!presetn) peak_live[0] |=> peak_power_error_flag[0];
  endproperty
  a_peak_set: assert property (p_peak_set) else $error("peak flag not set");
  property p_avg_set;
    @(posedge pclk) disable iff (!presetn) avg_live[0] |=> average_power_error_flag[0];
  endproperty
  a_avg_set: assert property (p_avg_set) else $error("avg flag not set");
  property p_sticky_hold;
    @(posedge pclk) disable iff (!presetn)
      average_power_error_flag[0] && sticky_avg_reg[0] && !flag_rst_wr && !ev_clr_wr
      |=> average_power_error_flag[0];
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag dropped");
  property p_err_capture;
    @(posedge pclk) disable iff (!presetn)
      avg_live[0] |=> average_error_power_latch[0] == $past(avg_now[0]);
  endproperty
  a_err_capture: assert property (p_err_capture) else $error("error power not captured");
  property p_err_keep;
    @(posedge pclk) disable iff (!presetn) !avg_live[0] |=> $stable(average_error_power_latch[0]);
  endproperty
  a_err_keep: assert property (p_err_keep) else $error("error power changed");
  property p_mask_keep;
    @(posedge pclk) disable iff (!presetn)
      flag_rst_wr && !pwdata[0] && !ev_clr_wr && sticky_avg_reg[0] && average_power_error_flag[0]
      |=> average_power_error_flag[0];
  endproperty
  a_mask_keep: assert property (p_mask_keep) else $error("unselected channel cleared");
  property p_sel_avg;
    @(posedge pclk) disable iff (!presetn)
      flag_rst_wr && pwdata[9:8] == 2'h1 && pwdata[0] && sticky_peak_reg[0] && peak_power_error_flag[0]
      |=> peak_power_error_flag[0];
  endproperty
  a_sel_avg: assert property (p_sel_avg) else $error("select 1 cleared peak");
  property p_avg_result;
    @(posedge pclk) disable iff (!presetn) avg_done[0] |=> average_power_result[0] == $past(avg_now[0]);
  endproperty
  a_avg_result: assert property (p_avg_result) else $error("average result stale");
endmodule

//--- design/tpep_cfg.svh
// Register map, field layout and sizing constants for the PA protection error block
`ifndef TPEP_CFG_SVH
`define TPEP_CFG_SVH
`define TPEP_CH_N 4
`define TPEP_OFF_CTRL 12'h000
`define TPEP_OFF_STICKY 12'h004
`define TPEP_OFF_FLAGRST 12'h008
`define TPEP_OFF_EVCLR 12'h00C
`define TPEP_OFF_FLAGS 12'h010
`define TPEP_OFF_IRQ_STAT 12'h014
`define TPEP_OFF_IRQ_EN 12'h018
`define TPEP_OFF_IRQ_CLR 12'h01C
`define TPEP_OFF_WIN 12'h020
`define TPEP_OFF_CH_BASE 12'h040
`define TPEP_CH_STRIDE_LSB 5
`define TPEP_CH_STRIDE_W 2
`define TPEP_OFF_CH_AVGLIM 3'h0
`define TPEP_OFF_CH_PKLIM 3'h1
`define TPEP_OFF_CH_PKCNT 3'h2
`define TPEP_OFF_CH_AVG 3'h3
`define TPEP_OFF_CH_RATIO 3'h4
`define TPEP_OFF_CH_ERRPWR 3'h5
`define TPEP_SEL_AVG 2'h1
`define TPEP_SEL_PEAK 2'h2
`define TPEP_WIN_RST 4'h8
`define TPEP_AVG_LIM_RST 16'h2000
`define TPEP_PK_LIM_RST 16'h2000
`define TPEP_PK_CNT_RST 8'h04
`define TPEP_RATIO_SHIFT 15
`endif

//--- design/tpep_pkg.sv
// Types shared by the PA protection error block
package tpep_pkg;
  typedef logic [15:0] tpep_pwr_t;
  typedef logic [3:0] tpep_chmask_t;
endpackage

//--- dv/tpep_src.sv
// Transmit sample source model feeding the per-channel power strobes
`timescale 1ns/1ps
module tpep_src
  import tpep_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Sample stream
  output logic [3:0] sample_valid,
  output logic [63:0] sample_power
);
  // Idle stream at time zero
  initial begin
    sample_valid = 4'h0;
    sample_power = 64'h0;
  end

  // Back-to-back samples on one channel, then a quiet gap
  task automatic send(input int ch, input tpep_pwr_t pwr, input int n);
    repeat (n) begin
      @(posedge pclk);
      sample_valid <= 4'h1 << ch;
      sample_power[16*ch +: 16] <= pwr;
    end
    @(posedge pclk);
    sample_valid <= 4'h0;
    sample_power <= ~sample_power; // Stale data scrambled once released
    repeat (4) @(posedge pclk);
  endtask
endmodule

//--- dv/tb.sv
// Self-checking bench for the PA protection error block
`timescale 1ns/1ps
`include "tpep_cfg.svh"
module tb
  import tpep_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pll_unlock_in, deframer_irq_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, general_purpose_irq_out, pll_event_out, deframer_event_out, se;
  logic [3:0] sample_valid;
  logic [63:0] sample_power;
  int err_count, checked;

  // Design and sample source
  tpep_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .sample_power(sample_power), .pll_unlock_in(pll_unlock_in),
    .deframer_irq_in(deframer_irq_in), .general_purpose_irq_out(general_purpose_irq_out),
    .pll_event_out(pll_event_out), .deframer_event_out(deframer_event_out));
  tpep_src src (.pclk(pclk), .sample_valid(sample_valid), .sample_power(sample_power));

  // Clock at 100 MHz
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Word comparison
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer, bounded wait for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      summarize();
    end
  endtask

  // Read and compare one register
  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  // Let registered outputs follow a write before looking at them
  task automatic settle();
    repeat (2) @(posedge pclk);
  endtask

  // Byte address inside a channel block
  function automatic logic [11:0] cha(input int ch, input logic [11:0] off);
    return `TPEP_OFF_CH_BASE + 12'(ch * 32) + off;
  endfunction

  // Reset values, unmapped access, setup
  task automatic t_reset();
    rdchk("sticky", `TPEP_OFF_STICKY, 32'h000000FF);
    rdchk("window", `TPEP_OFF_WIN, 32'h00000008);
    rdchk("avg limit", cha(0, 12'h000), 32'h00002000);
    rdchk("peak limit", cha(0, 12'h004), 32'h00002000);
    rdchk("peak count", cha(0, 12'h008), 32'h00000004);
    rdchk("flags", `TPEP_OFF_FLAGS, 32'h0);
    chk("mapped err", 32'h0, {31'h0, se});
    chk("irq", 32'h0, {31'h0, general_purpose_irq_out});
    apb(1'b0, 12'hFFC, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped err", 32'h1, {31'h0, se});
    apb(1'b1, `TPEP_OFF_CTRL, 32'h00000FFF);
    apb(1'b1, `TPEP_OFF_WIN, 32'h00000002);
    apb(1'b1, `TPEP_OFF_IRQ_EN, 32'h0);
    apb(1'b1, cha(0, 12'h000), 32'h00000100);
    $display("test reset done");
  endtask

  // Average error, capture and status fields
  task automatic t_avg_err();
    src.send(0, 16'h0200, 4);
    rdchk("flags", `TPEP_OFF_FLAGS, 32'h1);
    chk("irq", 32'h1, {31'h0, general_purpose_irq_out});
    rdchk("error power", cha(0, 12'h014), 32'h00000200);
    rdchk("avg result", cha(0, 12'h00C), 32'h00000200);
    rdchk("ratio", cha(0, 12'h010), 32'h00008000);
    $display("test avg_err done");
  endtask

  // Sticky hold, masked and selective flag reset, interrupt mask and clear
  task automatic t_sticky();
    src.send(0, 16'h0010, 4);
    rdchk("avg result", cha(0, 12'h00C), 32'h00000010);
    rdchk("error power", cha(0, 12'h014), 32'h00000200);
    rdchk("flags", `TPEP_OFF_FLAGS, 32'h1);
    apb(1'b1, `TPEP_OFF_FLAGRST, 32'h00000302);
    rdchk("flags", `TPEP_OFF_FLAGS, 32'h1);
    apb(1'b1, `TPEP_OFF_FLAGRST, 32'h00000201);
    rdchk("flags", `TPEP_OFF_FLAGS, 32'h1);
    apb(1'b1, `TPEP_OFF_FLAGRST, 32'h00000101);
    rdchk("flags", `TPEP_OFF_FLAGS, 32'h0);
    chk("irq masked", 32'h0, {31'h0, general_purpose_irq_out});
    apb(1'b1, `TPEP_OFF_IRQ_EN, 32'h0000000F);
    settle();
    chk("irq enabled", 32'h1, {31'h0, general_purpose_irq_out});
    apb(1'b1, `TPEP_OFF_IRQ_CLR, 32'h0000000F);
    rdchk("irq status", `TPEP_OFF_IRQ_STAT, 32'h0);
    chk("irq cleared", 32'h0, {31'h0, general_purpose_irq_out});
    $display("test sticky done");
  endtask

  // Peak count boundary, both flags, event clear
  task automatic t_peak();
    apb(1'b1, cha(0, 12'h004), 32'h00000100);
    apb(1'b1, cha(0, 12'h008), 32'h00000001);
    src.send(0, 16'h0300, 1);
    rdchk("flags", `TPEP_OFF_FLAGS, 32'h0);
    src.send(0, 16'h0300, 1);
    rdchk("flags", `TPEP_OFF_FLAGS, 32'h10);
    src.send(0, 16'h0300, 2);
    rdchk("flags", `TPEP_OFF_FLAGS, 32'h11);
    rdchk("error power", cha(0, 12'h014), 32'h00000300);
    apb(1'b1, `TPEP_OFF_FLAGRST, 32'h00000101);
    rdchk("flags", `TPEP_OFF_FLAGS, 32'h10);
    apb(1'b1, `TPEP_OFF_EVCLR, 32'h00000001);
    rdchk("flags", `TPEP_OFF_FLAGS, 32'h0);
    apb(1'b1, `TPEP_OFF_IRQ_CLR, 32'h0000000F);
    settle();
    chk("irq", 32'h0, {31'h0, general_purpose_irq_out});
    $display("test peak done");
  endtask

  // Live mode follows each window and ignores clears
  task automatic t_live();
    apb(1'b1, `TPEP_OFF_STICKY, 32'h0);
    src.send(0, 16'h0300, 4);
    apb(1'b0, `TPEP_OFF_FLAGS, 32'h0);
    chk("live avg flag", 32'h1, {31'h0, rd[0]});
    apb(1'b1, `TPEP_OFF_FLAGRST, 32'h00000301);
    apb(1'b0, `TPEP_OFF_FLAGS, 32'h0);
    chk("live avg flag", 32'h1, {31'h0, rd[0]});
    src.send(0, 16'h0010, 4);
    rdchk("flags", `TPEP_OFF_FLAGS, 32'h0);
    apb(1'b1, `TPEP_OFF_IRQ_CLR, 32'h0000000F);
    settle();
    chk("irq", 32'h0, {31'h0, general_purpose_irq_out});
    $display("test live done");
  endtask

  // PLL and deframer events: flag reset leaves them, event clear removes them
  task automatic t_events();
    for (int i = 0; i < 2; i++) begin
      pll_unlock_in <= (i == 0);
      deframer_irq_in <= (i == 1);
      repeat (2) @(posedge pclk);
      pll_unlock_in <= 1'b0;
      deframer_irq_in <= 1'b0;
      rdchk("event flag", `TPEP_OFF_FLAGS, 32'h1 << (16 + i));
      apb(1'b1, `TPEP_OFF_FLAGRST, 32'h0000030F);
      chk("event kept", 32'h1, {31'h0, i == 0 ? pll_event_out : deframer_event_out});
      apb(1'b1, `TPEP_OFF_EVCLR, 32'h1 << (16 + i));
      rdchk("event flag", `TPEP_OFF_FLAGS, 32'h0);
      chk("event gone", 32'h0, {31'h0, i == 0 ? pll_event_out : deframer_event_out});
    end
    $display("test events done");
  endtask

  // Main sequence
  initial begin
    err_count = 0;
    checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pll_unlock_in = 1'b0;
    deframer_irq_in = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_avg_err();
    t_sticky();
    t_peak();
    t_live();
    t_events();
    summarize();
  end
endmodule
